// [mmsc_pkg.sv]
// Operation
// - bus control loads 0xD7 on reset/standby
// - strobe range field picks strobe address window
// - serial/timer control clears on reset/standby
// - select clear: FF88 and FFD8 shared addresses reach serial channels, FFA0 group decodes to none
// - select set: i2c and pwm registers decoded
// - flash select steers FF80 to FF87 window
// - clock select bits combine with timer selects
// - mode 1: 64k space, rom off, bus
// - mode 2: 16M advanced, rom on, single-chip
// - modes 2,3 expanded: ports 1,2 inputs until direction set
// - mode 3: 64k space, rom on, single-chip
// - mode 3 rom limited to 56 kbytes
// - mode 1 port 4 lines 3-5 fixed, lines 6,7 set by system control
// - modes 2,3 ports general until expanded
// - strobe enable picks address or i/o strobe
// - expanded enable fixed 1 in mode 1
package mmsc_pkg;
    localparam logic [11:0] ADDR_BUS_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_SERIAL_TIMER_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_MODE_CONTROL = 12'h008;
    localparam logic [11:0] ADDR_SYSTEM_CONTROL = 12'h00C;
    localparam logic [11:0] ADDR_PORT_DIRECTION = 12'h010;
    localparam logic [7:0] BUS_CONTROL_RESET = 8'hD7;
    localparam logic [7:0] SERIAL_TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SERIAL_TIMER_WRITE_MASK = 8'h7B;
    localparam int STROBE_RANGE_LO_BIT = 0;
    localparam int STROBE_RANGE_HI_BIT = 1;
    localparam int FLASH_ACCESS_SELECT_BIT = 3;
    localparam int I2C_ACCESS_SELECT_BIT = 4;
    localparam int EXPANDED_MODE_ENABLE_BIT = 7;
    localparam int STROBE_MODE_ENABLE_BIT = 0;
    localparam logic [15:0] STROBE_BASE = 16'hF000;
    localparam logic [15:0] STROBE_TOP_0 = 16'hF03F;
    localparam logic [15:0] STROBE_TOP_1 = 16'hF0FF;
    localparam logic [15:0] STROBE_TOP_2 = 16'hF3FF;
    localparam logic [15:0] STROBE_TOP_3 = 16'hFE4F;
    localparam logic [15:0] FLASH_WIN_LO = 16'hFF80;
    localparam logic [15:0] FLASH_WIN_HI = 16'hFF87;
    localparam logic [15:0] SHARED_A0 = 16'hFF88;
    localparam logic [15:0] SHARED_A1 = 16'hFF89;
    localparam logic [15:0] SHARED_A2 = 16'hFF8E;
    localparam logic [15:0] SHARED_A3 = 16'hFF8F;
    localparam logic [15:0] SHARED_B0 = 16'hFFA0;
    localparam logic [15:0] SHARED_B1 = 16'hFFA1;
    localparam logic [15:0] SHARED_B2 = 16'hFFA6;
    localparam logic [15:0] SHARED_B3 = 16'hFFA7;
    localparam logic [15:0] SHARED_C0 = 16'hFFD8;
    localparam logic [15:0] SHARED_C1 = 16'hFFD9;
    localparam logic [15:0] SHARED_C2 = 16'hFFDE;
    localparam logic [15:0] SHARED_C3 = 16'hFFDF;
    localparam logic [16:0] ROM_LIMIT_MODE3 = 17'h0E000;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;
    typedef enum logic [3:0] {
        SEL_NONE, SEL_SERIAL_ONE, SEL_SERIAL_ZERO, SEL_I2C_ONE, SEL_I2C_ZERO,
        SEL_PWM, SEL_FLASH, SEL_POWER_DOWN
    } mmsc_target_t;
endpackage : mmsc_pkg

// [mmsc_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module mmsc_decode (
    // request
    input wire logic [15:0] cpu_addr,
    input wire logic i2c_access_select,
    input wire logic flash_access_select,
    // result
    output mmsc_pkg::mmsc_target_t target
);
    function automatic logic in_quad(input logic [15:0] a, input logic [15:0] b0,
        input logic [15:0] b3);
        in_quad = (a == b0) || (a == b0 + 16'h0001) || (a == b3 - 16'h0001) || (a == b3);
    endfunction : in_quad

    always_comb
    begin
        target = mmsc_pkg::SEL_NONE;
        if (cpu_addr >= mmsc_pkg::FLASH_WIN_LO && cpu_addr <= mmsc_pkg::FLASH_WIN_HI)
            target = flash_access_select ? mmsc_pkg::SEL_FLASH : mmsc_pkg::SEL_POWER_DOWN;
        else if (in_quad(cpu_addr, mmsc_pkg::SHARED_A0, mmsc_pkg::SHARED_A3))
            target = i2c_access_select ? mmsc_pkg::SEL_I2C_ONE : mmsc_pkg::SEL_SERIAL_ONE;
        else if (in_quad(cpu_addr, mmsc_pkg::SHARED_C0, mmsc_pkg::SHARED_C3))
            target = i2c_access_select ? mmsc_pkg::SEL_I2C_ZERO : mmsc_pkg::SEL_SERIAL_ZERO;
        else if (i2c_access_select && in_quad(cpu_addr, mmsc_pkg::SHARED_B0, mmsc_pkg::SHARED_B3))
            target = mmsc_pkg::SEL_PWM;
    end
endmodule : mmsc_decode
`default_nettype wire

// [mmsc_strobe.sv]
`timescale 1ns/1ps
`default_nettype none
module mmsc_strobe (
    // access
    input wire logic [15:0] ext_addr,
    input wire logic ext_access,
    // control
    input wire logic strobe_mode_enable,
    input wire logic [1:0] strobe_range,
    // pin level
    output logic strobe_low
);
    logic [15:0] top;
    always_comb
    begin
        unique case (strobe_range)
            2'h0: top = mmsc_pkg::STROBE_TOP_0;
            2'h1: top = mmsc_pkg::STROBE_TOP_1;
            2'h2: top = mmsc_pkg::STROBE_TOP_2;
            2'h3: top = mmsc_pkg::STROBE_TOP_3;
        endcase
        if (strobe_mode_enable)
            strobe_low = ext_access && ext_addr >= mmsc_pkg::STROBE_BASE && ext_addr <= top;
        else
            strobe_low = ext_access;
    end
endmodule : mmsc_strobe
`default_nettype wire

// [mmsc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module mmsc_top (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device state
    input wire logic [1:0] mode_pins,
    input wire logic hw_standby,
    input wire logic [15:0] port_direction_12,
    // cpu access
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_access,
    input wire logic [2:0] timer_clock_select,
    // results
    output mmsc_pkg::mmsc_target_t shared_target,
    output logic shared_strobe_pin_o,
    output logic shared_strobe_pin_oe,
    output logic [4:0] timer_clock_code,
    output logic rom_enable,
    output logic advanced_mode,
    output logic rom_access_ok,
    output logic [15:0] port12_addr_out,
    output logic port3_data_bus,
    output logic [7:3] port4_control
);
    logic [7:0] bus_control_reg, bus_control_next;
    logic [7:0] serial_timer_control_reg, serial_timer_control_next;
    logic expanded_mode_enable_reg, expanded_mode_enable_next;
    logic strobe_en_reg, strobe_en_next;
    logic p46_port_reg, p46_port_next;
    logic p47_ctrl_reg, p47_ctrl_next;
    logic [31:0] prdata_next;
    logic wr, rd_setup, expanded, ext_access, strobe_low, mode1;

    assign wr = psel && penable && pwrite;
    // read data is fetched in the setup cycle so it already stands at the access edge
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign mode1 = (mode_pins == mmsc_pkg::MODE_1);

    always_comb
    begin
        bus_control_next = bus_control_reg;
        serial_timer_control_next = serial_timer_control_reg;
        expanded_mode_enable_next = expanded_mode_enable_reg;
        strobe_en_next = strobe_en_reg;
        p46_port_next = p46_port_reg;
        p47_ctrl_next = p47_ctrl_reg;
        if (wr)
        begin
            unique case (paddr)
                mmsc_pkg::ADDR_BUS_CONTROL: bus_control_next = pwdata[7:0];
                mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL:
                    serial_timer_control_next = pwdata[7:0] & mmsc_pkg::SERIAL_TIMER_WRITE_MASK;
                mmsc_pkg::ADDR_MODE_CONTROL:
                    expanded_mode_enable_next =
                        mode1 ? 1'b1 : pwdata[mmsc_pkg::EXPANDED_MODE_ENABLE_BIT];
                mmsc_pkg::ADDR_SYSTEM_CONTROL:
                begin
                    strobe_en_next = pwdata[mmsc_pkg::STROBE_MODE_ENABLE_BIT];
                    p46_port_next = pwdata[1];
                    p47_ctrl_next = pwdata[2];
                end
                default: ;
            endcase
        end
        if (hw_standby)
        begin
            bus_control_next = mmsc_pkg::BUS_CONTROL_RESET;
            serial_timer_control_next = mmsc_pkg::SERIAL_TIMER_CONTROL_RESET;
            expanded_mode_enable_next = mode1;
            strobe_en_next = 1'b0;
            p46_port_next = 1'b0;
            p47_ctrl_next = 1'b0;
        end
        prdata_next = prdata;
        if (rd_setup)
        begin
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                mmsc_pkg::ADDR_BUS_CONTROL: prdata_next[7:0] = bus_control_reg;
                mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL: prdata_next[7:0] = serial_timer_control_reg;
                mmsc_pkg::ADDR_MODE_CONTROL:
                    prdata_next[7:0] = {expanded_mode_enable_reg, 5'h00, mode_pins};
                mmsc_pkg::ADDR_SYSTEM_CONTROL:
                    prdata_next[2:0] = {p47_ctrl_reg, p46_port_reg, strobe_en_reg};
                default: ;
            endcase
        end
    end

    // mode 1 enable must read 1 from reset; strapped level caught at the first edge
    logic strap_seen_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_control_reg <= mmsc_pkg::BUS_CONTROL_RESET;
            serial_timer_control_reg <= mmsc_pkg::SERIAL_TIMER_CONTROL_RESET;
            expanded_mode_enable_reg <= 1'b0;
            strobe_en_reg <= 1'b0;
            p46_port_reg <= 1'b0;
            p47_ctrl_reg <= 1'b0;
            strap_seen_reg <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            bus_control_reg <= bus_control_next;
            serial_timer_control_reg <= serial_timer_control_next;
            expanded_mode_enable_reg <= strap_seen_reg ? expanded_mode_enable_next : mode1;
            strobe_en_reg <= strobe_en_next;
            p46_port_reg <= p46_port_next;
            p47_ctrl_reg <= p47_ctrl_next;
            strap_seen_reg <= 1'b1;
            prdata <= prdata_next;
        end
    end

    assign pslverr = psel && penable && !(paddr == mmsc_pkg::ADDR_BUS_CONTROL ||
        paddr == mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL || paddr == mmsc_pkg::ADDR_MODE_CONTROL ||
        paddr == mmsc_pkg::ADDR_SYSTEM_CONTROL);

    // mode 1 always expanded; modes 2 and 3 only once enabled
    assign expanded = mode1 || expanded_mode_enable_reg;
    assign rom_enable = !mode1;
    assign advanced_mode = (mode_pins == mmsc_pkg::MODE_2);
    // only 16 lines leave the chip, so the high address bits are simply dropped
    assign ext_access = cpu_access && expanded;
    assign rom_access_ok = !mode1 && !(mode_pins == mmsc_pkg::MODE_3 &&
        {1'b0, cpu_addr} >= mmsc_pkg::ROM_LIMIT_MODE3);
    assign timer_clock_code = {serial_timer_control_reg[1:0], timer_clock_select};
    assign shared_strobe_pin_oe = expanded;
    assign shared_strobe_pin_o = !strobe_low;
    assign port12_addr_out =
        mode1 ? 16'hFFFF : (expanded_mode_enable_reg ? port_direction_12 : 16'h0000);
    assign port3_data_bus = expanded;
    assign port4_control[5:3] = {3{expanded}};
    assign port4_control[6] = mode1 ? !p46_port_reg : expanded_mode_enable_reg;
    assign port4_control[7] = mode1 ? p47_ctrl_reg : expanded_mode_enable_reg;

    mmsc_decode u_decode (
        .cpu_addr(cpu_addr),
        .i2c_access_select(serial_timer_control_reg[mmsc_pkg::I2C_ACCESS_SELECT_BIT]),
        .flash_access_select(serial_timer_control_reg[mmsc_pkg::FLASH_ACCESS_SELECT_BIT]),
        .target(shared_target)
    );

    mmsc_strobe u_strobe (
        .ext_addr(cpu_addr),
        .ext_access(ext_access),
        .strobe_mode_enable(strobe_en_reg),
        .strobe_range(bus_control_reg[1:0]),
        .strobe_low(strobe_low)
    );
endmodule : mmsc_top
`default_nettype wire

// [mmsc_ext_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module mmsc_ext_dev (
    // pin from the device
    input wire logic strobe_o,
    input wire logic strobe_oe,
    // select seen by the peripheral
    output logic hit
);
    // a released pin floats to the pull-up, so only a driven low selects us
    assign hit = strobe_oe && !strobe_o;
endmodule : mmsc_ext_dev
`default_nettype wire

// [mmsc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mmsc_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs
    input wire logic [1:0] mode_pins,
    input wire logic cpu_access,
    input wire logic [15:0] cpu_addr,
    input wire logic [2:0] timer_clock_select,
    input wire logic [15:0] port_direction_12,
    // outputs
    input wire mmsc_pkg::mmsc_target_t shared_target,
    input wire logic shared_strobe_pin_o,
    input wire logic shared_strobe_pin_oe,
    input wire logic [4:0] timer_clock_code,
    input wire logic rom_enable,
    input wire logic advanced_mode,
    input wire logic [15:0] port12_addr_out,
    input wire logic port3_data_bus,
    input wire logic [7:3] port4_control
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_m1_run;
        $past(presetn) && mode_pins == mmsc_pkg::MODE_1;
    endsequence
    property p_rom; rom_enable == (mode_pins != mmsc_pkg::MODE_1); endproperty
    a_rom: assert property (p_rom) else $error("rom enable wrong for mode");
    property p_adv; advanced_mode == (mode_pins == mmsc_pkg::MODE_2); endproperty
    a_adv: assert property (p_adv) else $error("advanced mode wrong");
    property p_tmr; timer_clock_code[2:0] == timer_clock_select; endproperty
    a_tmr: assert property (p_tmr) else $error("timer select not passed");
    property p_pwm;
        shared_target == mmsc_pkg::SEL_PWM |-> cpu_addr inside {16'hFFA0, 16'hFFA1, 16'hFFA6, 16'hFFA7};
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm decoded off its addresses");
    property p_m1oe; s_m1_run |-> shared_strobe_pin_oe; endproperty
    a_m1oe: assert property (p_m1oe) else $error("mode 1 not expanded");
    property p_m1ctl; s_m1_run |-> port4_control[5:3] == 3'h7; endproperty
    a_m1ctl: assert property (p_m1ctl) else $error("mode 1 port 4 control lines");
    property p_idle; !cpu_access |-> shared_strobe_pin_o; endproperty
    a_idle: assert property (p_idle) else $error("strobe low without access");
    property p_dir;
        mode_pins != mmsc_pkg::MODE_1 |-> (port12_addr_out & ~port_direction_12) == 16'h0000;
    endproperty
    a_dir: assert property (p_dir) else $error("address out without direction");
    property p_single;
        !shared_strobe_pin_oe && mode_pins != mmsc_pkg::MODE_1
            |-> port12_addr_out == 16'h0000 && !port3_data_bus && port4_control == 5'h00;
    endproperty
    a_single: assert property (p_single) else $error("bus pins used in single chip");
endmodule : mmsc_props
bind mmsc_top mmsc_props u_props (.pclk, .presetn, .mode_pins, .cpu_access, .cpu_addr,
    .timer_clock_select, .port_direction_12, .shared_target, .shared_strobe_pin_o,
    .shared_strobe_pin_oe, .timer_clock_code, .rom_enable, .advanced_mode, .port12_addr_out,
    .port3_data_bus, .port4_control);
`default_nettype wire

// [test_mmsc_mode_and_strobe_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_mmsc_mode_and_strobe_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_standby = 0;
    logic cpu_access = 0, pready, pslverr, err, hit, rom_enable, advanced_mode;
    logic rom_access_ok, port3_data_bus, shared_strobe_pin_o, shared_strobe_pin_oe;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [1:0] mode_pins = 2'h3;
    logic [15:0] port_direction_12 = 0, cpu_addr = 0, port12_addr_out;
    logic [2:0] timer_clock_select = 3'h5;
    logic [4:0] timer_clock_code;
    logic [7:3] port4_control;
    mmsc_pkg::mmsc_target_t shared_target;
    int n_fail = 0, n_checks = 0;
    logic [15:0] ta [8] = '{16'hFF88, 16'hFF8F, 16'hFFA0, 16'hFFA6, 16'hFFD8, 16'hFFDF,
        16'hFF80, 16'hFF87};
    logic [15:0] tops [4] = '{16'hF03F, 16'hF0FF, 16'hF3FF, 16'hFE4F};
    // expected targets as nibbles in the enum order of the target type
    logic [31:0] sel [2] = '{32'h77220011, 32'h66445533};
    mmsc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mode_pins, .hw_standby, .port_direction_12, .cpu_addr, .cpu_access,
        .timer_clock_select, .shared_target, .shared_strobe_pin_o, .shared_strobe_pin_oe,
        .timer_clock_code, .rom_enable, .advanced_mode, .rom_access_ok, .port12_addr_out,
        .port3_data_bus, .port4_control);
    mmsc_ext_dev u_dev (.strobe_o(shared_strobe_pin_o), .strobe_oe(shared_strobe_pin_oe), .hit);
    initial forever #25 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rdc
    task automatic st(input logic [15:0] a, input logic e);
        cpu_addr <= a;
        cpu_access <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk("strobe hit", 32'(hit), 32'(e));
        @(posedge pclk);
    endtask : st
    task automatic rst(input logic [1:0] m);
        presetn <= 1'b0;
        mode_pins <= m;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst
    task automatic results;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial
    begin
        rst(2'h3);
        rdc("bus_control", mmsc_pkg::ADDR_BUS_CONTROL, 32'hD7);
        rdc("serial_timer", mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, 32'h00);
        rdc("mode_control", mmsc_pkg::ADDR_MODE_CONTROL, 32'h03);
        apb(1'b1, mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, 32'h7B);
        rdc("serial_timer", mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, 32'h7B);
        apb(1'b1, mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, 32'h03);
        chk("timer clock", 32'(timer_clock_code), {27'h0, 2'h3, timer_clock_select});
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, k ? 32'h18 : 32'h00);
            for (int i = 0; i < 8; i++)
            begin
                cpu_addr <= ta[i];
                @(posedge pclk);
                @(negedge pclk);
                chk("target", 32'(shared_target), 32'(sel[k][4*i+:4]));
                @(posedge pclk);
            end
        end
        $display("registers and decode done");
        apb(1'b1, mmsc_pkg::ADDR_BUS_CONTROL, 32'h00);
        hw_standby <= 1'b1;
        @(posedge pclk);
        hw_standby <= 1'b0;
        @(posedge pclk);
        rdc("bus_control", mmsc_pkg::ADDR_BUS_CONTROL, 32'hD7);
        rdc("serial_timer", mmsc_pkg::ADDR_SERIAL_TIMER_CONTROL, 32'h00);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        $display("standby and unmapped done");
        apb(1'b1, mmsc_pkg::ADDR_MODE_CONTROL, 32'h80);
        rdc("mode_control", mmsc_pkg::ADDR_MODE_CONTROL, 32'h83);
        port_direction_12 <= 16'h00FF;
        apb(1'b1, mmsc_pkg::ADDR_SYSTEM_CONTROL, 32'h00);
        st(16'hF040, 1'b1);
        apb(1'b1, mmsc_pkg::ADDR_SYSTEM_CONTROL, 32'h01);
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, mmsc_pkg::ADDR_BUS_CONTROL, 32'(r));
            st(tops[r], 1'b1);
            st(tops[r] + 16'h1, 1'b0);
        end
        chk("port12", 32'(port12_addr_out), 32'h00FF);
        chk("port3", 32'(port3_data_bus), 32'h1);
        cpu_addr <= 16'hDFFF;
        @(posedge pclk);
        chk("rom limit", 32'(rom_access_ok), 32'h1);
        cpu_addr <= 16'hE000;
        @(posedge pclk);
        chk("rom limit", 32'(rom_access_ok), 32'h0);
        $display("expanded mode 3 done");
        rst(2'h1);
        rdc("mode_control", mmsc_pkg::ADDR_MODE_CONTROL, 32'h81);
        apb(1'b1, mmsc_pkg::ADDR_MODE_CONTROL, 32'h00);
        rdc("mode_control", mmsc_pkg::ADDR_MODE_CONTROL, 32'h81);
        chk("rom", 32'(rom_enable), 32'h0);
        chk("port4", 32'(port4_control[5:3]), 32'h7);
        chk("port4 lines 47 46", 32'(port4_control[7:6]), 32'h1);
        apb(1'b1, mmsc_pkg::ADDR_SYSTEM_CONTROL, 32'h06);
        chk("port4 lines 47 46", 32'(port4_control[7:6]), 32'h2);
        rst(2'h2);
        rdc("mode_control", mmsc_pkg::ADDR_MODE_CONTROL, 32'h02);
        chk("advanced", 32'(advanced_mode), 32'h1);
        $display("modes 1 and 2 done");
        results();
    end
endmodule : test_mmsc_mode_and_strobe_control
`default_nettype wire
